// ==== async_tq_pkg.sv ====
package async_tq_pkg;
  // ************************************************
  // Register offsets (byte addresses)
  // ************************************************
  localparam logic [7:0] OFF_CTL = 8'h80;
  localparam logic [7:0] OFF_QSTATE = 8'h84;
  localparam logic [7:0] OFF_RQ_NEXT = 8'h88;
  localparam logic [7:0] OFF_RQ_LAST = 8'h8c;
  localparam logic [7:0] OFF_RP_NEXT = 8'h90;
  localparam logic [7:0] OFF_RP_LAST = 8'h94;
  localparam logic [7:0] OFF_RREQ = 8'h98;
  localparam logic [7:0] OFF_RRSP = 8'h9c;
  localparam logic [7:0] OFF_EVEN = 8'ha0;
  localparam logic [7:0] OFF_EVENT = 8'ha4;
  // ************************************************
  // Control field positions and reset values
  // ************************************************
  localparam int TOF_LSB = 0;
  localparam int TOS_LSB = 13;
  localparam int MAXRC_LSB = 16;
  localparam int ARXALL_BIT = 20;
  localparam int ARXRST_BIT = 21;
  localparam int ATXRST_BIT = 22;
  localparam logic [12:0] TOF_RST = 13'h0;
  localparam logic [2:0] TOS_RST = 3'h1;
  localparam logic [3:0] MAXRC_RST = 4'h0;
  localparam logic ARXALL_RST = 1'b0;
  localparam logic ATXRST_RST = 1'b1;
  localparam logic [15:0] EVEN_RST = 16'h0;
  // ************************************************
  // Event bits: tx queue q at 5*q, rx queue r at 8+4*r
  // ************************************************
  localparam int EV_WR = 0;
  localparam int EV_WRERR = 1;
  localparam int EV_TXFULL = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_RCVD = 4;
  localparam int EV_AV = 8;
  localparam int EV_LAST = 9;
  localparam int EV_RDERR = 10;
  localparam int EV_RXFULL = 11;
  localparam logic [15:0] EV_AUTO = 16'h3300;
  // ************************************************
  // Queue state bits, five per queue
  // ************************************************
  localparam int QS_EMPTY = 0;
  localparam int QS_5AV = 1;
  localparam int QS_AF = 2;
  localparam int QS_FULL = 3;
  localparam int QS_IDLE = 4;
  // ************************************************
  // Transaction status and timing
  // ************************************************
  localparam logic [3:0] STATUS_PENDING = 4'h2;
  localparam int FRAC_TIME_NS = 125000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FRAC_CYCLES = FRAC_TIME_NS / CLK_PERIOD_NS;
  localparam logic [16:0] FRACS_PER_SEC = 17'h1f40;
  // Quadlet with its end-of-packet mark
  typedef struct packed {
    logic last;
    logic [31:0] data;
  } quad_s;
  // Response intake state
  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_PKT = 1'b1
  } rx_e;
endpackage

// ==== async_transaction_queues.sv ====
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
// ************************************************
// Packet queue with commit and rewind points
// ************************************************
module sync_quad_fifo #(
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic push,
  input wire async_tq_pkg::quad_s pushQ,
  input wire logic abort,
  input wire logic pop,
  input wire logic rewind,
  output async_tq_pkg::quad_s head,
  output logic empty,
  output logic [$clog2(DEPTH):0] free
);
  localparam int AW = $clog2(DEPTH);
  async_tq_pkg::quad_s mem [DEPTH]; // Storage
  logic [AW:0] wrPtr; // Next free slot
  logic [AW:0] cmtPtr; // End of last whole packet
  logic [AW:0] rdPtr; // Head for reading
  logic [AW:0] pktPtr; // Start of packet being read
  assign head = mem[rdPtr[AW-1:0]];
  assign empty = (cmtPtr == rdPtr);
  // Space is held until a packet has been fully read
  assign free = (AW+1)'(DEPTH) - (wrPtr - pktPtr);
  // Storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= pushQ;
    end
  end
  // Pointer update
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      cmtPtr <= '0;
      rdPtr <= '0;
      pktPtr <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      cmtPtr <= '0;
      rdPtr <= '0;
      pktPtr <= '0;
    end else begin
      // Abort drops the unfinished packet
      wrPtr <= abort ? cmtPtr : wrPtr + (AW+1)'(push);
      if (push && pushQ.last) begin
        cmtPtr <= wrPtr + 1'b1;
      end
      rdPtr <= rewind ? pktPtr : rdPtr + (AW+1)'(pop);
      if (pop && head.last) begin
        pktPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule
// Behaviour
// - Registers are whole 32-bit quadlets
// - Writes to reserved bits are ignored
// - Control bits take defaults at power-on
// - Bus reset sets both read-error flags
// - Unsolicited responses dropped unless receive-all
// - Write overrun flags error, discards packet
// - Writing one clears an event flag
// - Transmit end queues one-quadlet confirmation
// - Confirmation carries transaction status
// - Missing response within timeout sets flag
// - Response sets received and available together
// - No last indication after read error
// - Acknowledged read error rewinds the packet
// - Written flag set, cleared by next write
// - Reading response clears available flag
// - Request ports decode at 0x088, 0x08c
// - Response and transfer ports decoded
// - Each event flag has an enable bit
// - Reading an empty queue sets read error
module async_transaction_queues #(
  parameter int DEPTH = 16,
  parameter int FRAC_CYCLES = async_tq_pkg::FRAC_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output async_tq_pkg::quad_s [1:0] txQuad,
  output logic [1:0] txValid,
  input wire logic [1:0] txTake,
  output logic [3:0] retryLimit,
  input wire logic txDone,
  input wire logic [3:0] txStatus,
  input wire async_tq_pkg::quad_s rxQuad,
  input wire logic rxValid,
  output logic rxReady,
  input wire logic busReset,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  // ************************************************
  // Address decode
  // ************************************************
  wire wrCtl = regWr && regAddr == async_tq_pkg::OFF_CTL;
  wire wrEn = regWr && regAddr == async_tq_pkg::OFF_EVEN;
  wire wrAck = regWr && regAddr == async_tq_pkg::OFF_EVENT;
  wire rqNext = regWr && regAddr == async_tq_pkg::OFF_RQ_NEXT;
  wire rqLast = regWr && regAddr == async_tq_pkg::OFF_RQ_LAST;
  wire rpNext = regWr && regAddr == async_tq_pkg::OFF_RP_NEXT;
  wire rpLast = regWr && regAddr == async_tq_pkg::OFF_RP_LAST;
  wire [1:0] portWr = {rpNext | rpLast, rqNext | rqLast};
  wire [1:0] portLast = {rpLast, rqLast};
  wire [1:0] rdTry; // Transfer register read attempts
  assign rdTry[0] = regRd && regAddr == async_tq_pkg::OFF_RREQ;
  assign rdTry[1] = regRd && regAddr == async_tq_pkg::OFF_RRSP;
  // ************************************************
  // Control register
  // ************************************************
  logic atxrst; // Transmitter held in reset
  logic arxrst; // Receiver flush request
  logic arxall; // Keep unsolicited responses
  logic [3:0] maxrc; // Retry count
  logic [2:0] tos; // Split timeout seconds
  logic [12:0] tof; // Split timeout fraction
  async_tq_pkg::rx_e rxState; // Response intake state
  logic [15:0] evt; // Event flags
  logic [15:0] evEn; // Event enables
  // Whole-quadlet write, reserved bits dropped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      atxrst <= async_tq_pkg::ATXRST_RST;
      arxall <= async_tq_pkg::ARXALL_RST;
      maxrc <= async_tq_pkg::MAXRC_RST;
      tos <= async_tq_pkg::TOS_RST;
      tof <= async_tq_pkg::TOF_RST;
      arxrst <= 1'b0;
    end else if (wrCtl) begin
      atxrst <= regWdata[async_tq_pkg::ATXRST_BIT];
      arxrst <= regWdata[async_tq_pkg::ARXRST_BIT];
      arxall <= regWdata[async_tq_pkg::ARXALL_BIT];
      maxrc <= regWdata[async_tq_pkg::MAXRC_LSB +: 4];
      tos <= regWdata[async_tq_pkg::TOS_LSB +: 3];
      tof <= regWdata[async_tq_pkg::TOF_LSB +: 13];
    end else begin
      // Receive-all returns to default on bus reset
      if (busReset) begin
        arxall <= async_tq_pkg::ARXALL_RST;
      end
      // Flush request clears once no packet is arriving
      if (rxState == async_tq_pkg::RX_IDLE) begin
        arxrst <= 1'b0;
      end
    end
  end
  assign retryLimit = maxrc;
  // ************************************************
  // Transmit queues: 0 request, 1 response
  // ************************************************
  logic [15:0] evSet; // Hardware set requests
  logic [15:0] evClr; // Clear requests
  logic [1:0] setWr, setErr, setFull;
  logic [4:0] qs [4]; // Per-queue state bits
  genvar q;
  generate
    for (q = 0; q < 2; q++) begin : g_tx
      async_tq_pkg::quad_s hold; // Staged quadlet
      async_tq_pkg::quad_s outQ; // Quadlet offered to link
      async_tq_pkg::quad_s head;
      logic holdV, drop, outV, empty;
      logic [AW:0] free;
      wire full = free == '0;
      wire moveNow = holdV && !full;
      // A write that finds the stage still blocked is an overrun
      wire overrun = portWr[q] && holdV && !moveNow;
      wire pop = txTake[q] && outV;
      // Staging register between host and queue
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          hold <= '0;
          holdV <= 1'b0;
          drop <= 1'b0;
        end else if (atxrst) begin
          holdV <= 1'b0;
          drop <= 1'b0;
        end else if (overrun) begin
          // Discard rest of the packet up to its final port write
          holdV <= 1'b0;
          drop <= !portLast[q];
        end else if (portWr[q]) begin
          hold <= {portLast[q], regWdata};
          holdV <= !drop;
          drop <= drop && !portLast[q];
        end else if (moveNow) begin
          holdV <= 1'b0;
        end
      end
      sync_quad_fifo #(.DEPTH(DEPTH)) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .flush(atxrst),
        .push(moveNow),
        .pushQ(hold),
        .abort(overrun),
        .pop(pop),
        .rewind(1'b0),
        .head(head),
        .empty(empty),
        .free(free)
      );
      // Registered offer to the link transmitter
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          outV <= 1'b0;
          outQ <= '0;
        end else begin
          outV <= !empty && !pop && !atxrst;
          outQ <= head;
        end
      end
      assign txValid[q] = outV;
      assign txQuad[q] = outQ;
      assign setWr[q] = moveNow;
      assign setErr[q] = overrun;
      assign setFull[q] = moveNow && free == (AW+1)'(1);
      assign qs[q] = {!holdV, full, free == (AW+1)'(1), free >= (AW+1)'(5), empty};
    end
  endgenerate
  // ************************************************
  // Split transaction tracking
  // ************************************************
  logic pending; // Response outstanding
  logic rspDone; // Response committed last cycle
  logic [15:0] fracCyc; // Cycles within one fraction
  logic [16:0] units; // Fractions elapsed
  wire [16:0] limit = 17'(tos) * async_tq_pkg::FRACS_PER_SEC + 17'(tof);
  wire confirmPend = txDone && txStatus == async_tq_pkg::STATUS_PENDING;
  wire [1:0] push;
  async_tq_pkg::quad_s pushQ [2];
  // Response packet matches only while a transaction is pending
  wire rspCommit = push[1] && rxQuad.last && pending;
  wire expired = pending && !rspCommit && units >= limit;
  // Timeout counter and response matching
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
      rspDone <= 1'b0;
      fracCyc <= '0;
      units <= '0;
    end else begin
      rspDone <= rspCommit && !busReset;
      if (busReset) begin
        pending <= 1'b0;
      end else if (confirmPend) begin
        pending <= 1'b1;
        fracCyc <= '0;
        units <= '0;
      end else if (rspCommit || expired) begin
        pending <= 1'b0;
      end else if (pending) begin
        if (fracCyc == 16'(FRAC_CYCLES - 1)) begin
          fracCyc <= '0;
          units <= units + 1'b1;
        end else begin
          fracCyc <= fracCyc + 1'b1;
        end
      end
    end
  end
  // ************************************************
  // Receive queues: 0 confirmations, 1 responses
  // ************************************************
  logic accReg; // Current packet is being kept
  wire rxFlush = arxrst || busReset;
  wire accept = (rxState == async_tq_pkg::RX_IDLE) ? (pending || arxall) : accReg;
  wire rxTake = rxValid && rxReady;
  assign push[0] = txDone;
  assign pushQ[0] = {1'b1, 28'h0, txStatus};
  assign push[1] = rxTake && accept;
  assign pushQ[1] = rxQuad;
  // Packet framing of incoming responses
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState <= async_tq_pkg::RX_IDLE;
      accReg <= 1'b0;
      rxReady <= 1'b0;
    end else begin
      rxReady <= !rxFlush && g_rx[1].free >= (AW+1)'(2);
      if (rxFlush) begin
        rxState <= async_tq_pkg::RX_IDLE;
      end else if (rxTake) begin
        accReg <= accept;
        rxState <= rxQuad.last ? async_tq_pkg::RX_IDLE : async_tq_pkg::RX_PKT;
      end
    end
  end
  logic [1:0] rdOk; // Accepted transfer reads
  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : g_rx
      localparam int B = 8 + 4 * r;
      async_tq_pkg::quad_s head;
      logic empty;
      logic [AW:0] free;
      wire rdErr = evt[B + 2];
      // Reads are refused while the read error stands
      assign rdOk[r] = rdTry[r] && !empty && !rdErr;
      // Acknowledging a read error rewinds to packet start
      wire rewind = wrAck && regWdata[B + 2] && rdErr;
      wire avNext = !empty && !rdOk[r] && !rdErr;
      sync_quad_fifo #(.DEPTH(DEPTH)) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .flush(rxFlush),
        .push(push[r] && !rxFlush),
        .pushQ(pushQ[r]),
        .abort(1'b0),
        .pop(rdOk[r]),
        .rewind(rewind),
        .head(head),
        .empty(empty),
        .free(free)
      );
      assign evSet[B] = avNext;
      assign evSet[B + 1] = avNext && head.last;
      assign evSet[B + 2] = busReset || (rdTry[r] && empty && !rdErr);
      assign evSet[B + 3] = push[r] && free == (AW+1)'(1);
      assign qs[2 + r] = {1'b0, free == '0, free == (AW+1)'(1), free >= (AW+1)'(5), empty};
    end
  endgenerate
  // ************************************************
  // Event flags, enables and interrupt
  // ************************************************
  assign evSet[async_tq_pkg::EV_WR] = setWr[0];
  assign evSet[async_tq_pkg::EV_WRERR] = setErr[0];
  assign evSet[async_tq_pkg::EV_TXFULL] = setFull[0];
  assign evSet[async_tq_pkg::EV_TIMEOUT] = expired;
  assign evSet[async_tq_pkg::EV_RCVD] = rspDone;
  assign evSet[5 + async_tq_pkg::EV_WR] = setWr[1];
  assign evSet[5 + async_tq_pkg::EV_WRERR] = setErr[1];
  assign evSet[5 + async_tq_pkg::EV_TXFULL] = setFull[1];
  // Write-one clear; written flags also clear on the next port write
  wire [15:0] ackMask = wrAck ? regWdata[15:0] : 16'h0;
  wire [15:0] portClr = {10'h0, portWr[1], 4'h0, portWr[0]};
  assign evClr = ackMask | portClr | async_tq_pkg::EV_AUTO;
  // Sticky flags except the EV_AUTO bits; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt <= 16'h0;
    end else begin
      evt <= evSet | (evt & ~evClr);
    end
  end
  // Enable register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evEn <= async_tq_pkg::EVEN_RST;
    end else if (wrEn) begin
      evEn <= regWdata[15:0];
    end
  end
  // Level interrupt from enabled flags
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((evSet | (evt & ~evClr)) & evEn);
    end
  end
  // ************************************************
  // Read data
  // ************************************************
  wire [31:0] ctlWord = (32'(atxrst) << async_tq_pkg::ATXRST_BIT) | (32'(arxall) << async_tq_pkg::ARXALL_BIT)
                      | (32'(maxrc) << async_tq_pkg::MAXRC_LSB) | (32'(tos) << async_tq_pkg::TOS_LSB)
                      | (32'(tof) << async_tq_pkg::TOF_LSB);
  wire [31:0] qsWord = {12'h0, qs[3], qs[2], qs[1], qs[0]};
  wire [31:0] rdMux = (regAddr == async_tq_pkg::OFF_CTL) ? ctlWord :
    (regAddr == async_tq_pkg::OFF_QSTATE) ? qsWord :
    (regAddr == async_tq_pkg::OFF_EVEN) ? {16'h0, evEn} :
    (regAddr == async_tq_pkg::OFF_EVENT) ? {16'h0, evt} :
    rdOk[0] ? g_rx[0].head.data :
    rdOk[1] ? g_rx[1].head.data : 32'h0;
  // Answer stands for the cycle after the read only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0;
    end else begin
      regRdata <= regRd ? rdMux : 32'h0;
    end
  end
endmodule

// ==== async_tq_monitor.sv ====
`timescale 1ns/10ps
// ****************************************
// Port checker for the transaction queues
// ****************************************
module async_tq_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire async_tq_pkg::quad_s [1:0] txQuad,
  input wire logic [1:0] txValid,
  input wire logic [1:0] txTake,
  input wire logic [3:0] retryLimit,
  input wire logic irq
);
  logic [3:0] maxrcSeen; // Last retry count written
  logic [15:0] enSeen; // Last enable mask written
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Shadow of host writes to control and enables
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      maxrcSeen <= async_tq_pkg::MAXRC_RST;
      enSeen <= async_tq_pkg::EVEN_RST;
    end else if (regWr && regAddr == async_tq_pkg::OFF_CTL) begin
      maxrcSeen <= regWdata[19:16];
    end else if (regWr && regAddr == async_tq_pkg::OFF_EVEN) begin
      enSeen <= regWdata[15:0];
    end
  end
  a_rdata_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_unmapped_read: assert property (regRd && regAddr == 8'h00 |=> regRdata == 32'h0)
    else $error("unmapped read returned data");
  a_req_port_wo: assert property (regRd && (regAddr == async_tq_pkg::OFF_RQ_NEXT ||
    regAddr == async_tq_pkg::OFF_RQ_LAST) |=> regRdata == 32'h0)
    else $error("request port readable");
  a_rsp_port_wo: assert property (regRd && (regAddr == async_tq_pkg::OFF_RP_NEXT ||
    regAddr == async_tq_pkg::OFF_RP_LAST) |=> regRdata == 32'h0)
    else $error("response port readable");
  a_ctl_reserved: assert property (regRd && regAddr == async_tq_pkg::OFF_CTL |=>
    regRdata[31:23] == 9'h0 && !regRdata[21])
    else $error("reserved control bits read nonzero");
  a_retry_follow: assert property (retryLimit == maxrcSeen)
    else $error("retry limit does not follow control write");
  a_take_drops: assert property (txValid[0] && txTake[0] |=> !txValid[0])
    else $error("offer not withdrawn after take");
  a_offer_holds: assert property (txValid[1] && !txTake[1] && !regWr |=>
    txValid[1] && $stable(txQuad[1]))
    else $error("offer changed before take");
  a_irq_masked: assert property (enSeen == 16'h0 && $past(enSeen) == 16'h0 |-> !irq)
    else $error("interrupt with all enables clear");
  a_irq_cause: assert property ($rose(irq) |-> $past(enSeen) != 16'h0)
    else $error("interrupt rose without enable");
endmodule
bind async_transaction_queues async_tq_monitor u_mon (.core_clk(core_clk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .txQuad(txQuad), .txValid(txValid), .txTake(txTake), .retryLimit(retryLimit), .irq(irq));

// ==== link_partner.sv ====
`timescale 1ns/10ps
// ****************************************
// Link-side model: drains queues, answers
// ****************************************
module link_partner (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire async_tq_pkg::quad_s [1:0] txQuad,
  input wire logic [1:0] txValid,
  output logic [1:0] txTake,
  output logic txDone,
  output logic [3:0] txStatus,
  output async_tq_pkg::quad_s rxQuad,
  output logic rxValid,
  input wire logic rxReady
);
  async_tq_pkg::quad_s reqSeen[$]; // Request quadlets sent
  async_tq_pkg::quad_s rspSeen[$]; // Response quadlets sent
  wire reqEnd = txTake[0] && txValid[0] && txQuad[0].last; // Request packet finished
  // Idle receive lines
  initial begin
    rxQuad = '{last: 1'b0, data: 32'h0};
    rxValid = 1'b0;
  end
  // Take each offered quadlet; report the end of a request
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txTake <= 2'b00;
      txDone <= 1'b0;
      txStatus <= 4'h0;
    end else begin
      txTake <= txValid & ~txTake;
      txDone <= reqEnd;
      txStatus <= reqEnd ? async_tq_pkg::STATUS_PENDING : ~txStatus;
      if (txTake[0] && txValid[0]) begin
        reqSeen.push_back(txQuad[0]);
      end
      if (txTake[1] && txValid[1]) begin
        rspSeen.push_back(txQuad[1]);
      end
    end
  end
  // Deliver a response packet, holding each quadlet until taken
  task automatic sendRsp(input int n, input logic [31:0] base);
    @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rxQuad <= '{last: (i == n - 1), data: base + i[31:0]};
      rxValid <= 1'b1;
      @(posedge core_clk);
      while (rxReady !== 1'b1) @(posedge core_clk);
    end
    rxValid <= 1'b0;
    rxQuad <= ~rxQuad;
  endtask
endmodule

// ==== async_transaction_queues_tb.sv ====
`timescale 1ns/10ps
module async_transaction_queues_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic core_clk, arst_n, regWr, regRd, txDone, rxValid, rxReady, busReset, irq;
  logic [7:0] regAddr; // Register address
  logic [31:0] regWdata, regRdata, d; // Bus data and last read
  async_tq_pkg::quad_s [1:0] txQuad; // Offered quadlets
  async_tq_pkg::quad_s rxQuad; // Incoming response
  logic [1:0] txValid, txTake;
  logic [3:0] retryLimit, txStatus;
  int failures, num_checks;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  async_transaction_queues #(.DEPTH(16), .FRAC_CYCLES(4)) dut (.core_clk(core_clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .txQuad(txQuad), .txValid(txValid), .txTake(txTake), .retryLimit(retryLimit), .txDone(txDone),
    .txStatus(txStatus), .rxQuad(rxQuad), .rxValid(rxValid), .rxReady(rxReady),
    .busReset(busReset), .irq(irq));
  link_partner link (.core_clk(core_clk), .arst_n(arst_n), .txQuad(txQuad), .txValid(txValid),
    .txTake(txTake), .txDone(txDone), .txStatus(txStatus), .rxQuad(rxQuad), .rxValid(rxValid),
    .rxReady(rxReady));
  // Clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ****************************************
  // Bus tasks and comparisons
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkq(input async_tq_pkg::quad_s got, input async_tq_pkg::quad_s exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
    if (m != 32'h0) chk(d & m, exp);
  endtask
  // Poll one event bit until it sets, bounded
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rdc(async_tq_pkg::OFF_EVENT, 32'h0, 32'h0);
      n++;
    end while (d[b] !== 1'b1 && n < 400);
    chk({31'h0, d[b]}, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    busReset = 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    rdc(async_tq_pkg::OFF_CTL, ALL, 32'h0040_2000);
    rdc(async_tq_pkg::OFF_EVEN, ALL, 32'h0);
    rdc(async_tq_pkg::OFF_QSTATE, ALL, 32'h0001_8e73);
    wr(8'h00, ALL);
    rdc(8'h00, ALL, 32'h0);
    rdc(async_tq_pkg::OFF_RQ_NEXT, ALL, 32'h0);
    $display("test defaults done");
    // Bus reset blocks receive reads until acknowledged
    @(posedge core_clk);
    busReset <= 1'b1;
    @(posedge core_clk);
    busReset <= 1'b0;
    rdc(async_tq_pkg::OFF_EVENT, 32'hffff, 32'h4400);
    rdc(async_tq_pkg::OFF_RREQ, ALL, 32'h0);
    wr(async_tq_pkg::OFF_EVENT, 32'h4400);
    rdc(async_tq_pkg::OFF_EVENT, 32'hffff, 32'h0);
    wr(async_tq_pkg::OFF_CTL, 32'hff03_0064);
    rdc(async_tq_pkg::OFF_CTL, ALL, 32'h0003_0064);
    chk({28'h0, retryLimit}, 32'h3);
    wr(async_tq_pkg::OFF_EVEN, 32'h8);
    $display("test init done");
    // Back-to-back writes overrun the request queue
    @(posedge core_clk);
    regWr <= 1'b1;
    for (int i = 0; i < 21; i++) begin
      regAddr <= (i == 20) ? async_tq_pkg::OFF_RQ_LAST : async_tq_pkg::OFF_RQ_NEXT;
      regWdata <= 32'h100 + i[31:0];
      @(posedge core_clk);
    end
    regWr <= 1'b0;
    rdc(async_tq_pkg::OFF_EVENT, 32'h6, 32'h6);
    chk({30'h0, txValid}, 32'h0);
    wr(async_tq_pkg::OFF_EVENT, 32'h7);
    rdc(async_tq_pkg::OFF_QSTATE, 32'h1f, 32'h13);
    $display("test overrun done");
    // Quadlet-synchronised request, confirmation, timeout
    wr(async_tq_pkg::OFF_RQ_NEXT, 32'hcafe_0001);
    poll(async_tq_pkg::EV_WR);
    wr(async_tq_pkg::OFF_RQ_LAST, 32'hcafe_0002);
    poll(async_tq_pkg::EV_WR);
    repeat (20) @(posedge core_clk);
    rdc(async_tq_pkg::OFF_EVENT, 32'h1, 32'h1);
    wr(async_tq_pkg::OFF_EVENT, 32'h1);
    rdc(async_tq_pkg::OFF_EVENT, 32'h1, 32'h0);
    chkq(link.reqSeen.pop_front(), {1'b0, 32'hcafe_0001});
    chkq(link.reqSeen.pop_front(), {1'b1, 32'hcafe_0002});
    poll(async_tq_pkg::EV_AV);
    rdc(async_tq_pkg::OFF_EVENT, 32'h300, 32'h300);
    rdc(async_tq_pkg::OFF_RREQ, ALL, {28'h0, async_tq_pkg::STATUS_PENDING});
    rdc(async_tq_pkg::OFF_EVENT, 32'h8, 32'h0);
    poll(async_tq_pkg::EV_TIMEOUT);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(async_tq_pkg::OFF_EVENT, 32'h8);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test timeout done");
    // Response in time, read out, then an empty read
    wr(async_tq_pkg::OFF_RQ_LAST, 32'hbeef_0000);
    poll(async_tq_pkg::EV_AV);
    rdc(async_tq_pkg::OFF_RREQ, ALL, {28'h0, async_tq_pkg::STATUS_PENDING});
    chkq(link.reqSeen.pop_front(), {1'b1, 32'hbeef_0000});
    link.sendRsp(2, 32'h5a5a_0000);
    poll(async_tq_pkg::EV_RCVD);
    rdc(async_tq_pkg::OFF_EVENT, 32'h1010, 32'h1010);
    rdc(async_tq_pkg::OFF_RRSP, ALL, 32'h5a5a_0000);
    poll(12);
    rdc(async_tq_pkg::OFF_EVENT, 32'h2000, 32'h2000);
    rdc(async_tq_pkg::OFF_RRSP, ALL, 32'h5a5a_0001);
    repeat (2) @(posedge core_clk);
    rdc(async_tq_pkg::OFF_EVENT, 32'h1000, 32'h0);
    rdc(async_tq_pkg::OFF_RRSP, ALL, 32'h0);
    rdc(async_tq_pkg::OFF_EVENT, 32'h6000, 32'h4000);
    wr(async_tq_pkg::OFF_EVENT, 32'h4000);
    $display("test response done");
    // Unsolicited response dropped; response port drained
    link.sendRsp(1, 32'h7777_0000);
    repeat (10) @(posedge core_clk);
    rdc(async_tq_pkg::OFF_QSTATE, 32'h000f_8000, 32'h0001_8000);
    wr(async_tq_pkg::OFF_RP_LAST, 32'h1234_5678);
    repeat (10) @(posedge core_clk);
    chkq(link.rspSeen.pop_front(), {1'b1, 32'h1234_5678});
    $display("test unsolicited done");
    report_and_stop;
  end
endmodule
